// ==== hdl/fetch_ctl.sv ====
`timescale 1ns/1ps
// reset qualifier, mode entry and external memory strobe generator
// assumes core presents requests at machine cycle start and holds them one cycle
module fetch_ctl (
  // clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    ce_i,
  // pins sampled synchronously
  input  wire logic                    rst_pin_i,
  input  wire logic                    fetch_strobe_pin_i,
  input  wire logic [7:0]              port3_i,
  // configuration and core requests
  input  wire logic                    x2_i,
  input  wire fetch_ctl_pkg::mc_req_t  req_i,
  // fetch strobe pin, two-way
  output logic                         program_fetch_strobe_n_o,
  output logic                         program_fetch_strobe_oe_o,
  // data strobes on port 3
  output logic                         data_wr_n_o,
  output logic                         data_rd_n_o,
  // state and alternate inputs
  output logic                         core_reset_o,
  output fetch_ctl_pkg::op_mode_t      mode_o,
  output fetch_ctl_pkg::p3_alt_t       p3_alt_o
);
  logic [3:0]              phase;          // clock within machine cycle
  logic                    mc_end;         // last clock of machine cycle
  logic [3:0]              half;           // clocks in half a machine cycle
  logic [4:0]              rst_mc_ff;      // machine cycles reset pin held high
  logic                    rst_pin_ff;     // previous rst pin sample
  logic                    strobe_pin_ff;  // previous fetch strobe pin sample
  logic                    fell_ff;        // falling edge seen while reset held
  fetch_ctl_pkg::mc_req_t  req_ff;         // request latched for current cycle
  logic                    rst_long;       // reset held over programming limit
  logic                    nxt_strobe_n;   // next fetch strobe level

  mc_timer u_mc_timer (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .ce_i     (ce_i),
    .x2_i     (x2_i),
    .phase_o  (phase),
    .mc_end_o (mc_end)
  );

  assign half     = x2_i ? (fetch_ctl_pkg::CLKS_X2 >> 1) : (fetch_ctl_pkg::CLKS_STD >> 1);
  assign rst_long = (rst_mc_ff > fetch_ctl_pkg::PROG_HOLD_MC);

  // count whole machine cycles the reset pin stays high, see RL5
  // saturates so a very long hold never wraps back below the entry limit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_mc_ff <= 5'h00;
    end else if (ce_i) begin
      if (!rst_pin_i) begin
        rst_mc_ff <= 5'h00;
      end else if (mc_end && rst_mc_ff != fetch_ctl_pkg::MC_CNT_MAX) begin
        rst_mc_ff <= rst_mc_ff + 5'h01;
      end
    end
  end

  // pin history for edge detection
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_pin_ff    <= 1'b0;
      strobe_pin_ff <= 1'b1;
    end else if (ce_i) begin
      rst_pin_ff    <= rst_pin_i;
      strobe_pin_ff <= fetch_strobe_pin_i;
    end
  end

  // catch a forced falling edge of the fetch strobe pin while reset is high, see RL4
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fell_ff <= 1'b0;
    end else if (ce_i) begin
      if (!rst_pin_i) begin
        fell_ff <= 1'b0;
      end else if (strobe_pin_ff && !fetch_strobe_pin_i) begin
        fell_ff <= 1'b1;
      end
    end
  end

  // hold core in reset once qualified, see RL5
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_reset_o <= 1'b1;
    end else if (ce_i) begin
      core_reset_o <= rst_pin_i && (rst_mc_ff >= fetch_ctl_pkg::RST_QUAL_MC);
    end
  end

  // choose mode at release of the reset pin, see RL6 and RL4
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o <= fetch_ctl_pkg::MODE_RESET;
    end else if (ce_i) begin
      if (rst_pin_i && rst_mc_ff >= fetch_ctl_pkg::RST_QUAL_MC) begin
        mode_o <= fetch_ctl_pkg::MODE_RESET;
      end else if (rst_pin_ff && !rst_pin_i && mode_o == fetch_ctl_pkg::MODE_RESET) begin
        // entry needs both the edge and a long enough hold
        mode_o <= (fell_ff && rst_long) ? fetch_ctl_pkg::MODE_HOST
                                        : fetch_ctl_pkg::MODE_NORMAL;
      end
    end
  end

  // latch core request at machine cycle boundary
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_ff <= '0;
    end else if (ce_i && mc_end) begin
      req_ff <= req_i;
    end
  end

  // fetch strobe low in the second half of each half cycle
  always_comb begin
    nxt_strobe_n = 1'b1;
    if (mode_o == fetch_ctl_pkg::MODE_NORMAL && req_ff.ext_code        // see RL1
        && !req_ff.data_rd && !req_ff.data_wr) begin                   // see RL3
      // two pulses per machine cycle, see RL2
      nxt_strobe_n = !((phase >= (half >> 1) && phase < half) ||
                       (phase >= half + (half >> 1)));
    end
  end

  // drive fetch strobe; pin released while in reset so a programmer may force it
  // oe also drops while the reset pin is high, so a forced edge is never fought
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      program_fetch_strobe_n_o  <= 1'b1;
      program_fetch_strobe_oe_o <= 1'b0;
    end else if (ce_i) begin
      program_fetch_strobe_n_o  <= nxt_strobe_n;
      program_fetch_strobe_oe_o <= (mode_o == fetch_ctl_pkg::MODE_NORMAL) && !rst_pin_i;
    end
  end

  // data strobes low across the second half of an access cycle, see RL7 and RL8
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_wr_n_o <= 1'b1;
      data_rd_n_o <= 1'b1;
    end else if (ce_i) begin
      data_wr_n_o <= !(mode_o == fetch_ctl_pkg::MODE_NORMAL && req_ff.data_wr
                       && phase >= half);
      data_rd_n_o <= !(mode_o == fetch_ctl_pkg::MODE_NORMAL && req_ff.data_rd
                       && phase >= half);
    end
  end

  // alternate port 3 inputs registered, see RL9
  // bits 0 and 1 belong to the serial port and bits 6, 7 are outputs here
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      p3_alt_o <= '0;
    end else if (ce_i) begin
      p3_alt_o.ext_irq0_in     <= port3_i[fetch_ctl_pkg::P3_IRQ0_BIT];
      p3_alt_o.ext_irq1_in     <= port3_i[fetch_ctl_pkg::P3_IRQ1_BIT];
      p3_alt_o.timer0_count_in <= port3_i[fetch_ctl_pkg::P3_T0_BIT];
      p3_alt_o.timer1_count_in <= port3_i[fetch_ctl_pkg::P3_T1_BIT];
    end
  end

  // fetch strobe shape
  AST_INT_HIGH: assert property (@(posedge clk_i) disable iff (reset_i) // see RL1
    (ce_i && !req_ff.ext_code) |=> program_fetch_strobe_n_o)
    else $error("fetch strobe low during internal fetch");
  AST_SKIP: assert property (@(posedge clk_i) disable iff (reset_i) // see RL3
    (ce_i && (req_ff.data_rd || req_ff.data_wr)) |=> program_fetch_strobe_n_o)
    else $error("fetch strobe not skipped on data access");
  AST_EXT_PULSE: assert property (@(posedge clk_i) disable iff (reset_i) // see RL2
    ($past(ce_i) && !program_fetch_strobe_n_o)
    |-> $past(req_ff.ext_code && mode_o == fetch_ctl_pkg::MODE_NORMAL))
    else $error("fetch strobe low without external fetch");
  // reset qualification and mode entry
  AST_RST_QUAL: assert property (@(posedge clk_i) disable iff (reset_i) // see RL5
    (ce_i && rst_pin_i && rst_mc_ff >= fetch_ctl_pkg::RST_QUAL_MC) |=> core_reset_o)
    else $error("reset not applied after qualification");
  AST_NO_EARLY: assert property (@(posedge clk_i) disable iff (reset_i) // see RL5
    (ce_i && !rst_pin_i && !core_reset_o) |=> !core_reset_o)
    else $error("reset without pin high");
  AST_HOST: assert property (@(posedge clk_i) disable iff (reset_i) // see RL4
    (ce_i && rst_pin_ff && !rst_pin_i && fell_ff && rst_long
     && mode_o == fetch_ctl_pkg::MODE_RESET) |=> mode_o == fetch_ctl_pkg::MODE_HOST)
    else $error("host mode not entered");
  AST_NORMAL: assert property (@(posedge clk_i) disable iff (reset_i) // see RL6
    (ce_i && rst_pin_ff && !rst_pin_i && !fell_ff
     && mode_o == fetch_ctl_pkg::MODE_RESET) |=> mode_o == fetch_ctl_pkg::MODE_NORMAL)
    else $error("normal mode not entered");
  AST_HOST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // see RL4
    (ce_i && !rst_pin_i && mode_o == fetch_ctl_pkg::MODE_HOST)
    |=> mode_o == fetch_ctl_pkg::MODE_HOST)
    else $error("host mode left without reset");
  AST_OE_RST: assert property (@(posedge clk_i) disable iff (reset_i) // see RL4
    (ce_i && rst_pin_i) |=> !program_fetch_strobe_oe_o)
    else $error("fetch strobe driven while reset pin high");
  // data strobes and port 3; a frozen cycle is skipped since the request may have moved on
  AST_WR: assert property (@(posedge clk_i) disable iff (reset_i) // see RL7
    ($past(ce_i) && !data_wr_n_o) |-> $past(req_ff.data_wr))
    else $error("write strobe without write");
  AST_RD: assert property (@(posedge clk_i) disable iff (reset_i) // see RL8
    ($past(ce_i) && !data_rd_n_o) |-> $past(req_ff.data_rd))
    else $error("read strobe without read");
  AST_WR_HALF: assert property (@(posedge clk_i) disable iff (reset_i) // see RL7
    ($past(ce_i) && !data_wr_n_o) |-> $past(phase) >= $past(half))
    else $error("write strobe in first half of cycle");
  AST_T0: assert property (@(posedge clk_i) disable iff (reset_i) // see RL9
    ce_i |=> p3_alt_o.timer0_count_in == $past(port3_i[fetch_ctl_pkg::P3_T0_BIT]))
    else $error("timer 0 input not passed");
  AST_T1: assert property (@(posedge clk_i) disable iff (reset_i) // see RL9
    ce_i |=> p3_alt_o.timer1_count_in == $past(port3_i[fetch_ctl_pkg::P3_T1_BIT]))
    else $error("timer 1 input not passed");
  // machine cycle length
  AST_LEN: assert property (@(posedge clk_i) disable iff (reset_i) // see RL10
    (ce_i && !x2_i && phase == 4'h0) |=> phase == 4'h1)
    else $error("phase did not advance");
  AST_MC_END: assert property (@(posedge clk_i) disable iff (reset_i) // see RL10
    (ce_i && !x2_i && mc_end) |-> phase == fetch_ctl_pkg::CLKS_STD - 4'h1)
    else $error("standard machine cycle ended at wrong phase");
endmodule

// ==== hdl/fetch_ctl_pkg.sv ====
// constants and carrier types for the reset qualifier and fetch strobe block
// assumes a single 100 MHz clock taken as the oscillator, pins sampled synchronously
// What this block does
// RL1: internal fetch keeps fetch strobe high
// RL2: external fetch pulses strobe twice per cycle
// RL3: data access skips two fetch strobes
// RL4: reset over 10 cycles plus edge enters programming
// RL5: reset after two cycles of high pin
// RL6: normal mode unless strobe fell during a reset held over 10 cycles
// RL7: port 3 bit 6 marks data writes
// RL8: port 3 bit 7 marks data reads
// RL9: port 3 bits 4,5 feed timer counts
// RL10: machine cycle twelve clocks, six in double
package fetch_ctl_pkg;
  localparam int unsigned CLK_MHZ        = 100;       // oscillator rate
  localparam logic [3:0]  CLKS_STD       = 4'hC;      // clocks per machine cycle, normal
  localparam logic [3:0]  CLKS_X2        = 4'h6;      // clocks per machine cycle, double speed
  localparam logic [4:0]  RST_QUAL_MC    = 5'h02;     // machine cycles to qualify a reset
  localparam logic [4:0]  PROG_HOLD_MC   = 5'h0A;     // reset must exceed this for entry
  localparam logic [4:0]  MC_CNT_MAX     = 5'h1F;     // saturation of machine cycle counter
  localparam int unsigned P3_IRQ0_BIT    = 3'h2;      // port 3 bit for external interrupt 0
  localparam int unsigned P3_IRQ1_BIT    = 3'h3;      // port 3 bit for external interrupt 1
  localparam int unsigned P3_T0_BIT      = 3'h4;      // port 3 bit for timer 0 count input
  localparam int unsigned P3_T1_BIT      = 3'h5;      // port 3 bit for timer 1 count input

  // operating mode chosen on leaving reset
  typedef enum logic [1:0] {
    MODE_RESET  = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_HOST   = 2'b10
  } op_mode_t;

  // one request from the core for the current machine cycle
  typedef struct packed {
    logic ext_code;   // fetching from external program memory
    logic data_rd;    // external data read this cycle
    logic data_wr;    // external data write this cycle
  } mc_req_t;

  // alternate port 3 inputs passed to the timer and interrupt logic
  typedef struct packed {
    logic ext_irq0_in;
    logic ext_irq1_in;
    logic timer0_count_in;
    logic timer1_count_in;
  } p3_alt_t;
endpackage

// ==== hdl/mc_timer.sv ====
`timescale 1ns/1ps
// machine cycle timer: counts oscillator clocks and marks phase points
// assumes clock enable gates everything, mode select is static during use
module mc_timer (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // configuration
  input  wire logic       x2_i,
  // phase outputs
  output logic [3:0]      phase_o,
  output logic            mc_end_o
);
  logic [3:0] len;  // clocks in one machine cycle

  // select cycle length, see RL10
  always_comb begin
    len = x2_i ? fetch_ctl_pkg::CLKS_X2 : fetch_ctl_pkg::CLKS_STD;
  end

  // wrap counter; a switch to the shorter cycle at or past its last phase restarts at phase 0 rather than overrunning
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_o <= 4'h0;
    end else if (ce_i) begin
      if (phase_o >= len - 4'h1) begin
        phase_o <= 4'h0;
      end else begin
        phase_o <= phase_o + 4'h1;
      end
    end
  end

  assign mc_end_o = (phase_o >= len - 4'h1);
endmodule

// ==== verif/fetch_partner.sv ====
`timescale 1ns/1ps
// far side of the fetch strobe wire: external memory and host programmer
// assumes the bench steers the host through host_en_i and host_lvl_i
module fetch_partner (
  // clock
  input  wire logic clk_i,
  // device side of the wire
  input  wire logic dev_n_i,
  input  wire logic dev_oe_i,
  // host programmer controls
  input  wire logic host_en_i,
  input  wire logic host_lvl_i,
  // resolved wire level
  output logic      pin_o
);
  logic float_ff = 1'b0;  // no pull-up on this wire, so a released line keeps changing

  // undriven wire toggles each clock so a stale value never passes for a level
  always @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end

  // host drives the wire while the device releases it, forcing its high-to-low edge on command
  assign pin_o = dev_oe_i ? dev_n_i : (host_en_i ? host_lvl_i : float_ff);
endmodule

// ==== verif/reset_mode_entry_and_fetch_strobe_tb.sv ====
`timescale 1ns/1ps
// self-checking bench for the reset qualifier and memory strobe block
// assumes the partner model resolves the fetch strobe wire
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module reset_mode_entry_and_fetch_strobe_tb;
  logic                    clk_i = 1'b0;
  logic                    reset_i = 1'b1;
  logic                    ce_i = 1'b1;
  logic                    rst_pin_i = 1'b0;
  logic [7:0]              port3_i = 8'h00;
  logic                    x2_i = 1'b0;
  fetch_ctl_pkg::mc_req_t  req_i = '0;
  logic                    host_en = 1'b0, host_lvl = 1'b1, pin;
  logic                    fs_n, fs_oe, wr_n, rd_n, core_rst;
  fetch_ctl_pkg::op_mode_t mode;
  fetch_ctl_pkg::p3_alt_t  p3_alt;
  int                      err_count = 0, samples_checked = 0;
  int                      fcnt = 0, rcnt = 0, wcnt = 0;  // strobe falls seen

  fetch_ctl dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .rst_pin_i(rst_pin_i),
    .fetch_strobe_pin_i(pin), .port3_i(port3_i), .x2_i(x2_i), .req_i(req_i),
    .program_fetch_strobe_n_o(fs_n), .program_fetch_strobe_oe_o(fs_oe),
    .data_wr_n_o(wr_n), .data_rd_n_o(rd_n), .core_reset_o(core_rst),
    .mode_o(mode), .p3_alt_o(p3_alt));
  fetch_partner far (.clk_i(clk_i), .dev_n_i(fs_n), .dev_oe_i(fs_oe),
    .host_en_i(host_en), .host_lvl_i(host_lvl), .pin_o(pin));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // strobe fall counters, phase-free way to count pulses per window
  always @(negedge fs_n) fcnt++;
  always @(negedge rd_n) rcnt++;
  always @(negedge wr_n) wcnt++;

  // wait n machine cycles at the current speed
  task automatic mc(input int n);
    repeat (n * (x2_i ? fetch_ctl_pkg::CLKS_X2 : fetch_ctl_pkg::CLKS_STD)) @(negedge clk_i);
  endtask

  // hold a steady request, then count strobe falls over n whole cycles
  task automatic strobes(input logic x2, input fetch_ctl_pkg::mc_req_t r, input int n,
                         input int ef, input int er, input int ew);
    x2_i = x2;
    req_i = r;
    mc(3);
    fcnt = 0; rcnt = 0; wcnt = 0;
    mc(n);
    `CHK(fcnt, ef)
    `CHK(rcnt, er)
    `CHK(wcnt, ew)
    $display("strobe test x2=%0b req=%h done", x2, r);
  endtask

  // pulse the reset pin for n+1 machine cycles, with or without a host edge in the last
  task automatic pin_reset(input int n, input logic edge_on, input fetch_ctl_pkg::op_mode_t m);
    req_i = '0;
    host_en = 1'b1;  // host drives the wire high while reset pin is high, then low for the last cycle when edge_on is set
    host_lvl = 1'b1;
    rst_pin_i = 1'b1;
    mc(n);
    `CHK(core_rst, 1'b1)
    if (edge_on) host_lvl = 1'b0;
    mc(1);
    rst_pin_i = 1'b0;
    repeat (4) @(negedge clk_i);
    host_en = 1'b0;
    `CHK(mode, m)
    $display("mode entry test n=%0d done", n);
  endtask

  // freeze the block with the clock enable: the fetch strobe may not move until it returns
  task automatic freeze();
    logic held;
    x2_i = 1'b0;
    req_i = 3'b100;
    mc(3);
    ce_i = 1'b0;
    held = fs_n;
    fcnt = 0;
    mc(4);
    `CHK(fcnt, 0)
    `CHK(fs_n, held)
    ce_i = 1'b1;
    mc(2);
    `CHK(fcnt, 4)
    $display("clock enable freeze test done");
  endtask

  // alternate port 3 inputs reach the timer and interrupt carrier
  task automatic alt_inputs();
    x2_i = 1'b0;
    port3_i = 8'h14;
    repeat (4) @(negedge clk_i);
    `CHK(p3_alt, 4'b1010)
    port3_i = 8'h28;
    repeat (4) @(negedge clk_i);
    `CHK(p3_alt, 4'b0101)
    $display("alternate input test done");
  endtask

  // closing verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    `CHK(fs_n, 1'b1)
    `CHK(mode, fetch_ctl_pkg::MODE_RESET)
    pin_reset(4, 1'b0, fetch_ctl_pkg::MODE_NORMAL);
    `CHK(core_rst, 1'b0)
    `CHK(fs_oe, 1'b1)
    strobes(1'b0, 3'b000, 4, 0, 0, 0);
    strobes(1'b0, 3'b100, 4, 8, 0, 0);
    strobes(1'b1, 3'b100, 4, 8, 0, 0);
    strobes(1'b0, 3'b110, 4, 0, 4, 0);
    strobes(1'b1, 3'b101, 4, 0, 0, 4);
    freeze();
    alt_inputs();
    pin_reset(5, 1'b1, fetch_ctl_pkg::MODE_NORMAL);
    pin_reset(12, 1'b1, fetch_ctl_pkg::MODE_HOST);
    `CHK(fs_oe, 1'b0)
    final_report();
  end
endmodule
